// ===== rtl/scr_pkg.sv
package scr_pkg;
    // register map
    localparam logic [15:0] SCR_ADDR_CONFIG  = 16'h4000;
    localparam logic [15:0] SCR_ADDR_COMMAND = 16'h4001;
    localparam logic [15:0] SCR_ADDR_IRQ     = 16'h4002;
    localparam logic [15:0] SCR_ADDR_STATE   = 16'h4003;
    localparam logic [7:0]  SCR_RESET_VALUE  = 8'h00;
    // command codes
    localparam logic [7:0] SCR_CMD_NONE    = 8'h00;
    localparam logic [7:0] SCR_CMD_OPEN    = 8'h01;
    localparam logic [7:0] SCR_CMD_LISTEN  = 8'h02;
    localparam logic [7:0] SCR_CMD_CONNECT = 8'h04;
    // protocol_select field of socket_config
    localparam int SCR_PROTO_LSB = 0;
    localparam int SCR_PROTO_W   = 4;
    localparam logic [3:0] SCR_PROTO_CLOSED    = 4'h0;
    localparam logic [3:0] SCR_PROTO_TCP       = 4'h1;
    localparam logic [3:0] SCR_PROTO_UDP       = 4'h2;
    localparam logic [3:0] SCR_PROTO_RAW_IP    = 4'h3;
    localparam logic [3:0] SCR_PROTO_RAW_FRAME = 4'h4;
    localparam logic [3:0] SCR_PROTO_PPP       = 4'h5;
    // socket_state encodings
    localparam logic [7:0] SCR_ST_SHUT        = 8'h00;
    localparam logic [7:0] SCR_ST_INITIALISED = 8'h13;
    localparam logic [7:0] SCR_ST_LISTENING   = 8'h14;
    localparam logic [7:0] SCR_ST_CONNECTED   = 8'h17;
    localparam logic [7:0] SCR_ST_UDP_OPEN    = 8'h22;
    localparam logic [7:0] SCR_ST_RAW_IP      = 8'h32;
    localparam logic [7:0] SCR_ST_RAW_FRAME   = 8'h42;
    localparam logic [7:0] SCR_ST_PPP_SESSION = 8'h5F;
    // socket_irq_flags bit positions
    localparam int SCR_IRQ_CON     = 0;
    localparam int SCR_IRQ_TIMEOUT = 3;

    // host register access
    typedef struct packed {
        logic        wr;
        logic        rd;
        logic [15:0] addr;
        logic [7:0]  wdata;
    } scr_reg_req_t;

    // link-engine events back into the block
    typedef struct packed {
        logic peer_connected;  // handshake completed
        logic synack_failed;   // server side syn/ack undelivered
        logic arp_timeout;
        logic tcp_timeout;
        logic rst_received;
        logic bad_port_syn;    // syn to a port that does not exist
    } scr_link_evt_t;

    typedef enum logic [1:0] {
        SCR_ACT_NONE,
        SCR_ACT_LISTEN,
        SCR_ACT_CONNECT
    } scr_action_t;
endpackage

// ===== rtl/scr_decode.sv
`timescale 1ns/10ps
// maps protocol_select plus command to next state and engine action
module scr_decode (
    input  wire logic [7:0]          i_cmd,
    input  wire logic [3:0]          i_proto,
    input  wire logic [7:0]          i_state,
    output logic                     o_valid,
    output logic [7:0]               o_next_state,
    output scr_pkg::scr_action_t     o_action
);
    import scr_pkg::*;

    // invalid combos leave state alone
    always_comb begin
        o_valid      = 1'b0;
        o_next_state = i_state;
        o_action     = SCR_ACT_NONE;
        unique case (i_cmd)
            SCR_CMD_OPEN: begin
                o_valid = 1'b1;
                unique case (i_proto)
                    SCR_PROTO_TCP:       o_next_state = SCR_ST_INITIALISED;
                    SCR_PROTO_UDP:       o_next_state = SCR_ST_UDP_OPEN;
                    SCR_PROTO_RAW_IP:    o_next_state = SCR_ST_RAW_IP;
                    SCR_PROTO_RAW_FRAME: o_next_state = SCR_ST_RAW_FRAME;
                    SCR_PROTO_PPP:       o_next_state = SCR_ST_PPP_SESSION;
                    default:             o_valid      = 1'b0;
                endcase
            end
            SCR_CMD_LISTEN: begin
                // only from initialised tcp socket
                if (i_proto == SCR_PROTO_TCP &&
                    i_state == SCR_ST_INITIALISED) begin
                    o_valid      = 1'b1;
                    o_next_state = SCR_ST_LISTENING;
                    o_action     = SCR_ACT_LISTEN;
                end
            end
            SCR_CMD_CONNECT: begin
                if (i_proto == SCR_PROTO_TCP &&
                    i_state == SCR_ST_INITIALISED) begin
                    o_valid  = 1'b1;
                    o_action = SCR_ACT_CONNECT;
                end
            end
            default: o_valid = 1'b0;
        endcase
    end
endmodule // scr_decode

// ===== rtl/scr_socket_cmd.sv
`timescale 1ns/10ps
module scr_socket_cmd (
    input  wire logic                  i_core_clk,
    input  wire logic                  i_rst,
    input  wire logic                  i_clk_en,
    input  wire scr_pkg::scr_reg_req_t i_reg,
    output logic [7:0]                 o_rdata,
    input  wire scr_pkg::scr_link_evt_t i_evt,
    output logic                       o_send_syn,
    output logic                       o_send_rst,
    output logic                       o_listen_arm,
    output logic [7:0]                 o_socket_state,
    output logic [7:0]                 o_socket_irq_flags
);
    import scr_pkg::*;

    // host-visible registers
    logic [7:0]  config_q;
    logic [7:0]  config_d;
    logic [7:0]  command_q;
    logic [7:0]  command_d;
    logic [7:0]  rdata_q;
    logic [7:0]  rdata_d;

    // socket progress as seen by the host
    logic [7:0]  state_q;
    logic [7:0]  state_d;
    logic [7:0]  irq_q;
    logic [7:0]  irq_d;
    logic [7:0]  irq_set;
    logic [7:0]  irq_clr;

    // one-cycle requests to the link engine
    logic        syn_q;
    logic        syn_d;
    logic        rst_q;
    logic        rst_d;

    // decoder results for the pending command
    logic        dec_valid;
    logic [7:0]  dec_state;
    scr_action_t dec_action;
    logic [3:0]  proto;

    // qualified host writes and link outcomes
    logic        wr_config;
    logic        wr_command;
    logic        wr_irq;
    logic        cmd_pending;
    logic        listening;
    logic        connect_wait;
    logic        server_ok;
    logic        server_fail;
    logic        client_ok;
    logic        client_fail;
    logic        timeout_seen;

    // protocol_select field of socket_config
    assign proto = config_q[SCR_PROTO_LSB +: SCR_PROTO_W];

    scr_decode u_decode (
        .i_cmd        (command_q),
        .i_proto      (proto),
        .i_state      (state_q),
        .o_valid      (dec_valid),
        .o_next_state (dec_state),
        .o_action     (dec_action)
    );

    // host write decode by address
    assign wr_config   = i_reg.wr && (i_reg.addr == SCR_ADDR_CONFIG);
    assign wr_command  = i_reg.wr && (i_reg.addr == SCR_ADDR_COMMAND);
    assign wr_irq      = i_reg.wr && (i_reg.addr == SCR_ADDR_IRQ);
    assign cmd_pending = (command_q != SCR_CMD_NONE);

    // where the socket waits for the link engine
    // no pending state: outcomes after a bare open count as well
    assign listening    = (state_q == SCR_ST_LISTENING);
    assign connect_wait = (state_q == SCR_ST_INITIALISED) && !syn_q &&
                          !cmd_pending;

    // outcome decode; a connect result counts while initialised with no syn strobe and no command pending
    assign server_ok    = listening && i_evt.peer_connected;
    assign server_fail  = listening && !i_evt.peer_connected &&
                          (i_evt.synack_failed || i_evt.tcp_timeout);
    assign client_ok    = connect_wait && i_evt.peer_connected;
    assign client_fail  = connect_wait && !i_evt.peer_connected &&
                          (i_evt.arp_timeout || i_evt.tcp_timeout ||
                           i_evt.rst_received);
    assign timeout_seen = i_evt.arp_timeout || i_evt.tcp_timeout;

    // host registers; an accepted command stands one cycle, then clears
    always_comb begin
        config_d  = config_q;
        command_d = command_q;
        rdata_d   = rdata_q;
        if (cmd_pending) begin
            command_d = SCR_CMD_NONE;
        end
        if (wr_config) begin
            config_d = i_reg.wdata;
        end
        // a newer write replaces a command not yet taken up
        if (wr_command) begin
            command_d = i_reg.wdata;
        end
        // registered read data; unmapped addresses read as zero
        if (i_reg.rd) begin
            unique case (i_reg.addr)
                SCR_ADDR_CONFIG:  rdata_d = config_q;
                SCR_ADDR_COMMAND: rdata_d = command_q;
                SCR_ADDR_IRQ:     rdata_d = irq_q;
                SCR_ADDR_STATE:   rdata_d = state_q;
                default:          rdata_d = 8'h00;
            endcase
        end
    end

    // clock enable freezes the host registers
    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            config_q  <= SCR_RESET_VALUE;
            command_q <= SCR_RESET_VALUE;
            rdata_q   <= 8'h00;
        end else if (i_clk_en) begin
            config_q  <= config_d;
            command_q <= command_d;
            rdata_q   <= rdata_d;
        end
    end

    // socket state; a link outcome beats a command in the same cycle
    always_comb begin
        state_d = state_q;
        if (cmd_pending && dec_valid) begin
            state_d = dec_state;
        end
        if (server_ok || client_ok) begin
            state_d = SCR_ST_CONNECTED;
        end else if (server_fail || client_fail) begin
            state_d = SCR_ST_SHUT;
        end
    end

    // state register, frozen with the enable
    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            state_q <= SCR_ST_SHUT;
        end else if (i_clk_en) begin
            state_q <= state_d;
        end
    end

    // flags: host writes ones to clear, a same-cycle set wins
    always_comb begin
        irq_set                  = 8'h00;
        irq_set[SCR_IRQ_CON]     = server_ok || client_ok;
        irq_set[SCR_IRQ_TIMEOUT] = server_fail || timeout_seen;
        irq_clr                  = wr_irq ? i_reg.wdata : 8'h00;
        irq_d                    = (irq_q & ~irq_clr) | irq_set;
    end

    // flag register
    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            irq_q <= SCR_RESET_VALUE;
        end else if (i_clk_en) begin
            irq_q <= irq_d;
        end
    end

    // engine strobes last one enabled cycle; the engine must not stall
    always_comb begin
        syn_d = 1'b0;
        rst_d = 1'b0;
        if (cmd_pending && dec_valid &&
            dec_action == SCR_ACT_CONNECT) begin
            syn_d = 1'b1;
        end
        // a syn to a missing port gets a reset reply, state untouched
        if (i_evt.bad_port_syn) begin
            rst_d = 1'b1;
        end
    end

    // strobe registers
    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            syn_q <= 1'b0;
            rst_q <= 1'b0;
        end else if (i_clk_en) begin
            syn_q <= syn_d;
            rst_q <= rst_d;
        end
    end

    // registered status; the arm level is decoded from the state
    assign o_rdata            = rdata_q;
    assign o_listen_arm       = listening;
    assign o_socket_state     = state_q;
    assign o_socket_irq_flags = irq_q;

    // registered engine strobes
    assign o_send_syn         = syn_q;
    assign o_send_rst         = rst_q;
endmodule // scr_socket_cmd

// ===== verification/scr_socket_cmd_properties.sv
`timescale 1ns/10ps
module scr_socket_cmd_properties (
    input wire logic                   i_core_clk,
    input wire logic                   i_rst,
    input wire logic                   i_clk_en,
    input wire scr_pkg::scr_reg_req_t  i_reg,
    input wire logic [7:0]             o_rdata,
    input wire scr_pkg::scr_link_evt_t i_evt,
    input wire logic                   o_send_syn,
    input wire logic                   o_send_rst,
    input wire logic                   o_listen_arm,
    input wire logic [7:0]             o_socket_state,
    input wire logic [7:0]             o_socket_irq_flags
);
    import scr_pkg::*;
    default clocking @(posedge i_core_clk); endclocking
    default disable iff (i_rst);
    syn_pulse_a: assert property (i_clk_en && o_send_syn
        |=> !o_send_syn) else $error("syn pulse longer than one cycle");
    syn_cause_a: assert property (o_send_syn |-> $past(i_reg.wr, 2)
        && $past(i_reg.wdata, 2) == SCR_CMD_CONNECT)
        else $error("syn without connect command");
    rst_reply_a: assert property (i_clk_en && i_evt.bad_port_syn
        && o_socket_state == SCR_ST_LISTENING |=> o_send_rst
        && $stable(o_socket_state)) else $error("bad port not answered");
    server_open_a: assert property (i_clk_en && i_evt.peer_connected
        && o_socket_state == SCR_ST_LISTENING
        |=> o_socket_state == SCR_ST_CONNECTED && o_socket_irq_flags[0])
        else $error("server connection not reported");
    server_fail_a: assert property (i_clk_en && i_evt.synack_failed
        && o_socket_state == SCR_ST_LISTENING
        |=> o_socket_state == SCR_ST_SHUT && o_socket_irq_flags[3])
        else $error("server failure not reported");
    arp_close_a: assert property (i_clk_en && i_evt.arp_timeout
        && o_socket_state == SCR_ST_INITIALISED
        |=> o_socket_state == SCR_ST_SHUT) else $error("arp not closed");
    reset_close_a: assert property (i_clk_en && i_evt.rst_received
        && o_socket_state == SCR_ST_INITIALISED
        |=> o_socket_state == SCR_ST_SHUT) else $error("rst not closed");
    timeout_flag_a: assert property (i_clk_en
        && (i_evt.arp_timeout || i_evt.tcp_timeout)
        |=> o_socket_irq_flags[3]) else $error("timeout flag missing");
    listen_arm_a: assert property (o_listen_arm
        == (o_socket_state == SCR_ST_LISTENING)) else $error("arm wrong");
endmodule // scr_socket_cmd_properties
bind scr_socket_cmd scr_socket_cmd_properties scr_socket_cmd_properties_inst (
    .i_core_clk(i_core_clk), .i_rst(i_rst), .i_clk_en(i_clk_en),
    .i_reg(i_reg), .o_rdata(o_rdata), .i_evt(i_evt),
    .o_send_syn(o_send_syn), .o_send_rst(o_send_rst),
    .o_listen_arm(o_listen_arm), .o_socket_state(o_socket_state),
    .o_socket_irq_flags(o_socket_irq_flags));

// ===== verification/scr_host_model.sv
`timescale 1ns/10ps
// host side: completion is judged from state and flags, never command
module scr_host_model (
    input  wire logic             i_core_clk,
    output scr_pkg::scr_reg_req_t o_reg
);
    import scr_pkg::*;
    initial o_reg = '0;
    // request held across exactly one sampling edge
    task automatic access(input logic w, input logic [15:0] a,
                          input logic [7:0] d);
        @(posedge i_core_clk);
        o_reg <= '{wr: w, rd: !w, addr: a, wdata: d};
        @(posedge i_core_clk);
        o_reg <= '0;
    endtask
endmodule // scr_host_model

// ===== verification/tb_top.sv
`timescale 1ns/10ps
`define CHK(n, e, s) begin compares++; if ((s) !== (e)) begin errors++; \
    $display("wrong value %s expected %h seen %h", n, e, s); end end
module tb_top;
    import scr_pkg::*;
    logic          i_core_clk = 0, i_rst = 1, i_clk_en = 1;
    scr_reg_req_t  i_reg;
    scr_link_evt_t i_evt = '0;
    logic [7:0]    o_rdata, o_socket_state, o_socket_irq_flags, v;
    logic          o_send_syn, o_send_rst, o_listen_arm;
    int            errors = 0, compares = 0, syns = 0, rsts = 0;
    int            exp_st = 0, exp_fl = 0, p, c;
    int            st_tab [6] = '{0, 'h13, 'h22, 'h32, 'h42, 'h5F};
    always #25 i_core_clk = ~i_core_clk;
    // pulses are one cycle wide, so counting every edge is exact
    always @(posedge i_core_clk) begin
        syns += o_send_syn;
        rsts += o_send_rst;
    end
    scr_host_model scr_host_model_inst (.i_core_clk(i_core_clk),
                                        .o_reg(i_reg));
    scr_socket_cmd scr_socket_cmd_inst (.i_core_clk(i_core_clk),
        .i_rst(i_rst), .i_clk_en(i_clk_en), .i_reg(i_reg),
        .o_rdata(o_rdata), .i_evt(i_evt), .o_send_syn(o_send_syn),
        .o_send_rst(o_send_rst), .o_listen_arm(o_listen_arm),
        .o_socket_state(o_socket_state),
        .o_socket_irq_flags(o_socket_irq_flags));
    task automatic complete_run();
        $display("errors %0d compares %0d", errors, compares);
        if (errors == 0 && compares > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    // write, then let the clear edge and state update land
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        scr_host_model_inst.access(1'b1, a, d);
        repeat (3) @(posedge i_core_clk);
    endtask
    task automatic rd(input logic [15:0] a, output logic [7:0] d);
        scr_host_model_inst.access(1'b0, a, 8'h00);
        @(posedge i_core_clk);
        #1 d = o_rdata;
    endtask
    task automatic ev(input int b);
        @(posedge i_core_clk);
        i_evt <= scr_link_evt_t'(6'(1 << b));
        @(posedge i_core_clk);
        i_evt <= '0;
        repeat (2) @(posedge i_core_clk);
    endtask
    task automatic check(input int st, input int fl);
        #1 `CHK("state", st[7:0], o_socket_state)
        `CHK("flags", fl[7:0], o_socket_irq_flags)
    endtask
    task automatic open_tcp();
        wr(SCR_ADDR_CONFIG, 8'(SCR_PROTO_TCP));
        wr(SCR_ADDR_COMMAND, SCR_CMD_OPEN);
    endtask
    // watchdog in case the design hangs the run
    initial begin
        #2000000;
        errors++;
        complete_run();
    end
    initial begin
        void'($urandom(32'h20c1));
        repeat (3) @(posedge i_core_clk);
        i_rst <= 0;
        check(0, 0);
        // open with protocol codes 0 to 7, illegal ones refused
        for (p = 0; p < 8; p++) begin
            wr(SCR_ADDR_CONFIG, 8'(p));
            wr(SCR_ADDR_COMMAND, SCR_CMD_OPEN);
            if (p inside {[1:5]}) exp_st = st_tab[p];
            check(exp_st, 0);
        end
        wr(SCR_ADDR_COMMAND, SCR_CMD_LISTEN);
        check(exp_st, 0);
        c = $urandom_range(255, 8);
        wr(SCR_ADDR_COMMAND, 8'(c));
        check(exp_st, 0);
        rd(SCR_ADDR_COMMAND, v);
        `CHK("command", 8'h00, v)
        // server side: stray syn, then success or syn/ack failure
        for (p = 0; p < 2; p++) begin
            open_tcp();
            wr(SCR_ADDR_COMMAND, SCR_CMD_LISTEN);
            check('h14, exp_fl);
            `CHK("arm", 1'b1, o_listen_arm)
            ev(0);
            check('h14, exp_fl);
            ev(p ? 4 : 5);
            exp_fl |= p ? 8 : 1;
            check(p ? 0 : 'h17, exp_fl);
        end
        wr(SCR_ADDR_IRQ, 8'hFF);
        exp_fl = 0;
        // client side: success, arp and tcp timeout, received reset
        for (p = 1; p < 6; p++) if (p != 4) begin
            open_tcp();
            wr(SCR_ADDR_COMMAND, SCR_CMD_CONNECT);
            ev(p);
            exp_st = (p == 5) ? 'h17 : 0;
            exp_fl |= (p == 5) ? 1 : (p > 1) ? 8 : 0;
            check(exp_st, exp_fl);
        end
        rd(SCR_ADDR_STATE, v);
        `CHK("state read", exp_st[7:0], v)
        // host clear and timeout in one cycle: the set wins
        fork
            scr_host_model_inst.access(1'b1, SCR_ADDR_IRQ, 8'hFF);
            ev(2);
        join
        check(exp_st, 8);
        // enable held low: a command write is not taken
        @(posedge i_core_clk);
        i_clk_en <= 1'b0;
        wr(SCR_ADDR_COMMAND, SCR_CMD_OPEN);
        i_clk_en <= 1'b1;
        repeat (3) @(posedge i_core_clk);
        check(exp_st, 8);
        rd(SCR_ADDR_COMMAND, v);
        `CHK("frozen command", 8'h00, v)
        `CHK("syn count", 4, syns)
        `CHK("rst count", 2, rsts)
        complete_run();
    end
endmodule // tb_top
